// file: hdl/bcs_defines.vh
// Constants for the battery-backed clock SRAM host controller
`ifndef BCS_DEFINES_VH
`define BCS_DEFINES_VH
// Device map
`define BCS_ADDR_W          13
`define BCS_CLOCK_CONTROL   13'h1FF8
`define BCS_SECONDS_COUNT   13'h1FF9
`define BCS_MINUTES_COUNT   13'h1FFA
`define BCS_HOURS_COUNT     13'h1FFB
`define BCS_WEEKDAY_COUNT   13'h1FFC
`define BCS_DATE_COUNT      13'h1FFD
`define BCS_MONTH_COUNT     13'h1FFE
`define BCS_YEAR_COUNT      13'h1FFF
// Control byte fields
`define BCS_CTL_LOAD_BIT    7
`define BCS_CTL_HOLD_BIT    6
`define BCS_CTL_SIGN_BIT    5
`define BCS_CTL_CAL_MSB     4
`define BCS_SEC_HALT_BIT    7
`define BCS_DAY_FTEST_BIT   6
// Valid-bit masks of the time bytes, zero bits forced low
`define BCS_MASK_SECONDS    8'hFF
`define BCS_MASK_MINUTES    8'h7F
`define BCS_MASK_HOURS      8'h3F
`define BCS_MASK_WEEKDAY    8'h07
`define BCS_MASK_DATE       8'h3F
`define BCS_MASK_MONTH      8'h1F
`define BCS_MASK_YEAR       8'hFF
// Host registers
`define BCS_REG_ADDR        4'h0
`define BCS_REG_WDATA       4'h1
`define BCS_REG_CMD         4'h2
`define BCS_REG_STATUS      4'h3
`define BCS_REG_RDATA       4'h4
`define BCS_CMD_WRITE       2'h1
`define BCS_CMD_READ        2'h2
// Timing in ns at 25 ns clock
`define BCS_CLK_NS          25
`define BCS_SETUP_NS        0
`define BCS_PULSE_NS        130
`define BCS_DATA_NS         70
`define BCS_RECOVER_NS      10
`define BCS_ACCESS_NS       150
`define BCS_RECOVERY_DELAY_NS         1000
`define BCS_SETUP_CYC       ((`BCS_SETUP_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS + 1)
`define BCS_PULSE_CYC       ((`BCS_PULSE_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)
`define BCS_RECOVER_CYC     ((`BCS_RECOVER_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)
`define BCS_ACCESS_CYC      ((`BCS_ACCESS_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)
`define BCS_RECOVERY_DELAY_CYC        ((`BCS_RECOVERY_DELAY_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)
`endif

// file: hdl/bcs_timer.v
// Down counter that pulses done when a loaded count expires
module bcs_timer (
  input  wire       clk,
  input  wire       rst,
  input  wire       load,
  input  wire [7:0] count,
  output wire       busy,
  output wire       done
);
  reg [7:0] cnt_q;

  // Count down from the loaded value
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  assign busy = (cnt_q != 8'h00);
  assign done = (cnt_q == 8'h01);
endmodule // bcs_timer

// file: hdl/bcs_supply_gate.v
// Holds the device bus idle while supply is bad and for recovery afterwards
`include "bcs_defines.vh"
module bcs_supply_gate #(
  parameter RECOVERY_DELAY_CYC = `BCS_RECOVERY_DELAY_CYC
) (
  input  wire clk,
  input  wire rst,
  input  wire supply_ok,
  output wire bus_allowed
);
  // Recovery length cut to the counter width on purpose
  localparam integer RECOVERY_DELAY_I  = RECOVERY_DELAY_CYC;
  localparam [15:0]  RECOVERY_DELAY_16 = RECOVERY_DELAY_I[15:0];

  reg [15:0] rec_q;
  reg        ok_q;

  // Recovery count restarts each time the supply is seen bad
  always @(posedge clk) begin
    if (rst) begin
      rec_q <= 16'h0000;
      ok_q  <= 1'b0;
    end else if (!supply_ok) begin
      rec_q <= 16'h0000;
      ok_q  <= 1'b0;
    end else if (!ok_q) begin
      if (rec_q >= RECOVERY_DELAY_16 - 16'h0001) begin
        ok_q <= 1'b1;
      end else begin
        rec_q <= rec_q + 16'h0001;
      end
    end
  end

  assign bus_allowed = ok_q & supply_ok;
endmodule // bcs_supply_gate

// file: hdl/bcs_host.v
// Host controller driving the clock SRAM over its parallel bus
//
// Contract
// - Write only with all three strobes active
// - Address stable; recovery gap between cycles
// - Output drive held off while writing
// - Host keeps device deselected on power-up
// - Freeze updates before reading time bytes (not sequenced here; left to software)
// - Host writes zero to reserved bits
// - Time bytes are 24-hour BCD
`include "bcs_defines.vh"
module bcs_host #(
  parameter RECOVERY_DELAY_CYC = `BCS_RECOVERY_DELAY_CYC
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [31:0] reg_rdata,
  output reg  [12:0] address_lines,
  output reg  [7:0]  data_lines_out,
  output reg         data_lines_oe_n,
  input  wire [7:0]  data_lines_in,
  output reg         select_low_n,
  output reg         select_high,
  output reg         store_n,
  output reg         drive_n,
  input  wire        alert_in,
  output wire        alert_out,
  output wire        alert_oe_n,
  input  wire        supply_ok
);
  ////////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE  = 3'd0;
  localparam ST_SETUP = 3'd1;
  localparam ST_PULSE = 3'd2;
  localparam ST_HOLD  = 3'd3;
  localparam ST_READ  = 3'd4;
  localparam ST_REC   = 3'd5;

  ////////////////////////////////////////////////////////////////////////////
  // Timer reload values, cut to the timer width on purpose
  localparam integer SETUP_I   = `BCS_SETUP_CYC;
  localparam integer PULSE_I   = `BCS_PULSE_CYC;
  localparam integer RECOVER_I = `BCS_RECOVER_CYC;
  localparam integer ACCESS_I  = `BCS_ACCESS_CYC;
  localparam [7:0]   SETUP_8   = SETUP_I[7:0];
  localparam [7:0]   PULSE_8   = PULSE_I[7:0];
  localparam [7:0]   RECOVER_8 = RECOVER_I[7:0];
  localparam [7:0]   ACCESS_8  = ACCESS_I[7:0];

  // Freezing updates before reading time bytes is left to software;
  // this controller only moves single bytes and never sequences them.

  reg [2:0]  state_q;
  reg [12:0] addr_q;
  reg [7:0]  wdata_q;
  reg [7:0]  rdata_q;
  reg        is_write_q;
  reg        busy_q;
  reg        done_q;
  reg        abort_q;
  reg        tmr_load;
  reg [7:0]  tmr_count;
  wire       tmr_busy;
  wire       tmr_done;
  wire       bus_allowed;
  reg  [7:0] wmask;
  wire       cmd_code_ok;
  wire       cmd_take;

  // Command accepted only idle, with a known code and a good supply
  assign cmd_code_ok = (reg_wdata[1:0] == `BCS_CMD_WRITE) ||
                       (reg_wdata[1:0] == `BCS_CMD_READ);
  assign cmd_take    = reg_write && (reg_addr == `BCS_REG_CMD) && !busy_q &&
                       bus_allowed && cmd_code_ok;

  // Alert pin is only an input for the host; never driven
  assign alert_out  = 1'b0;
  assign alert_oe_n = 1'b1;

  bcs_timer u_timer (
    .clk   (clk),
    .rst   (rst),
    .load  (tmr_load),
    .count (tmr_count),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  bcs_supply_gate #(
    .RECOVERY_DELAY_CYC (RECOVERY_DELAY_CYC)
  ) u_gate (
    .clk         (clk),
    .rst         (rst),
    .supply_ok   (supply_ok & alert_in),
    .bus_allowed (bus_allowed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reserved bits of the time bytes are forced to zero
  always @* begin
    case (addr_q)
      `BCS_SECONDS_COUNT: begin
        wmask = `BCS_MASK_SECONDS;
      end
      `BCS_MINUTES_COUNT: begin
        wmask = `BCS_MASK_MINUTES;
      end
      `BCS_HOURS_COUNT: begin
        wmask = `BCS_MASK_HOURS;
      end
      `BCS_WEEKDAY_COUNT: begin
        wmask = `BCS_MASK_WEEKDAY;
      end
      `BCS_DATE_COUNT: begin
        wmask = `BCS_MASK_DATE;
      end
      `BCS_MONTH_COUNT: begin
        wmask = `BCS_MASK_MONTH;
      end
      `BCS_YEAR_COUNT: begin
        wmask = `BCS_MASK_YEAR;
      end
      default: begin
        wmask = 8'hFF; // Plain memory and control byte pass whole
      end
    endcase
  end

  // Host register writes and command capture
  always @(posedge clk) begin
    if (rst) begin
      addr_q     <= 13'h0000;
      wdata_q    <= 8'h00;
      is_write_q <= 1'b0;
    end else if (reg_write && !busy_q) begin
      if (reg_addr == `BCS_REG_ADDR) begin
        addr_q <= reg_wdata[12:0];
      end
      if (reg_addr == `BCS_REG_WDATA) begin
        wdata_q <= reg_wdata[7:0];
      end
      if (reg_addr == `BCS_REG_CMD) begin
        is_write_q <= (reg_wdata[1:0] == `BCS_CMD_WRITE);
      end
    end
  end

  // Register read mux, data one cycle after strobe
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      case (reg_addr)
        `BCS_REG_ADDR:   reg_rdata <= {19'h00000, addr_q};
        `BCS_REG_WDATA:  reg_rdata <= {24'h000000, wdata_q};
        `BCS_REG_STATUS: reg_rdata <= {27'h0000000, !alert_in, bus_allowed, abort_q, done_q, busy_q};
        `BCS_REG_RDATA:  reg_rdata <= {24'h000000, rdata_q};
        default:         reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle sequencer
  always @(posedge clk) begin
    tmr_load  <= 1'b0;
    tmr_count <= 8'h00;
    if (rst) begin
      state_q         <= ST_IDLE;
      busy_q          <= 1'b0;
      done_q          <= 1'b0;
      abort_q         <= 1'b0;
      rdata_q         <= 8'h00;
      address_lines   <= 13'h0000;
      data_lines_out  <= 8'h00;
      data_lines_oe_n <= 1'b1;
      select_low_n    <= 1'b1;
      select_high     <= 1'b0;
      store_n         <= 1'b1;
      drive_n         <= 1'b1;
    end else if (!bus_allowed && busy_q) begin
      // Supply lost: drop every strobe and report abort
      state_q         <= ST_IDLE;
      busy_q          <= 1'b0;
      abort_q         <= 1'b1;
      select_low_n    <= 1'b1;
      select_high     <= 1'b0;
      store_n         <= 1'b1;
      drive_n         <= 1'b1;
      data_lines_oe_n <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          select_low_n    <= 1'b1;
          select_high     <= 1'b0;
          store_n         <= 1'b1;
          drive_n         <= 1'b1;
          data_lines_oe_n <= 1'b1;
          if (cmd_take) begin
            busy_q        <= 1'b1;
            done_q        <= 1'b0;
            abort_q       <= 1'b0;
            address_lines <= addr_q;
            state_q       <= ST_SETUP;
            tmr_load      <= 1'b1;
            tmr_count     <= SETUP_8;
          end
        end
        ST_SETUP: begin
          // Address settled before any strobe
          if (tmr_done) begin
            select_low_n <= 1'b0;
            select_high  <= 1'b1;
            tmr_load     <= 1'b1;
            if (is_write_q) begin
              data_lines_out  <= wdata_q & wmask;
              data_lines_oe_n <= 1'b0;
              store_n         <= 1'b0;
              drive_n         <= 1'b1;
              tmr_count       <= PULSE_8;
              state_q         <= ST_PULSE;
            end else begin
              drive_n   <= 1'b0;
              tmr_count <= ACCESS_8;
              state_q   <= ST_READ;
            end
          end
        end
        ST_PULSE: begin
          // Store pulse releases first; data and address still held
          if (tmr_done) begin
            store_n   <= 1'b1;
            tmr_load  <= 1'b1;
            tmr_count <= RECOVER_8;
            state_q   <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Data and address outlive the store pulse by one step
          if (tmr_done) begin
            select_low_n    <= 1'b1;
            select_high     <= 1'b0;
            data_lines_oe_n <= 1'b1;
            tmr_load        <= 1'b1;
            tmr_count       <= RECOVER_8;
            state_q         <= ST_REC;
          end
        end
        ST_READ: begin
          // Sample once the access time has run out, then release
          if (tmr_done) begin
            rdata_q      <= data_lines_in;
            drive_n      <= 1'b1;
            select_low_n <= 1'b1;
            select_high  <= 1'b0;
            tmr_load     <= 1'b1;
            tmr_count    <= RECOVER_8;
            state_q      <= ST_REC;
          end
        end
        ST_REC: begin
          // Deselected gap before the next cycle, address held
          if (tmr_done) begin
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end
endmodule // bcs_host

// file: test/bcs_dev_model.sv
// Behavioural clock SRAM device on the far side of the host bus
module bcs_dev_model (
  input  wire logic [12:0] address_lines,
  input  wire logic [7:0]  data_lines_out,
  input  wire logic        select_low_n,
  input  wire logic        select_high,
  input  wire logic        store_n,
  input  wire logic        drive_n,
  input  wire logic        supply_ok,
  output logic      [7:0]  dq,
  output logic             alert_low
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [8192]; // Clock bytes are the top eight
  logic [7:0] last_q = 8'h5A;
  logic       wr_act;
  logic       rd_act;
  // Write window and read drive; bus ignored on bad supply
  assign wr_act = !select_low_n && select_high && !store_n && supply_ok;
  assign rd_act = !select_low_n && select_high && !drive_n && store_n && supply_ok;
  // Data present at the first releasing edge is stored
  always @(negedge wr_act) if (supply_ok) mem[address_lines] = data_lines_out;
  // Released lines show the inverse of the last value
  always @* if (rd_act) last_q = mem[address_lines];
  assign dq = rd_act ? mem[address_lines] : ~last_q;
  // Alert pulls low at once, never drives high
  assign alert_low = !supply_ok;
endmodule // bcs_dev_model

// file: test/bcs_host_checker.sv
// Pin-level assertions for the clock SRAM host controller
module bcs_host_checker #(
  parameter int RECOVERY_DELAY_CYC = 40
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [12:0] address_lines,
  input wire logic [7:0]  data_lines_out,
  input wire logic        data_lines_oe_n,
  input wire logic        select_low_n,
  input wire logic        select_high,
  input wire logic        store_n,
  input wire logic        drive_n,
  input wire logic        alert_in,
  input wire logic        alert_oe_n,
  input wire logic        supply_ok
);
  timeunit 1ns;
  timeprecision 100ps;
  int   good_q;
  logic ok_w;
  assign ok_w = supply_ok && alert_in;
  // Good-supply cycles since the last loss
  always @(posedge clk) begin
    if (rst || !ok_w) good_q <= 0;
    else if (good_q < 1000) good_q <= good_q + 1;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  a_write_strobes: assert property (!store_n |-> !select_low_n && select_high)
    else $error("store pulse without both selects");
  a_no_contention: assert property (!store_n |-> drive_n && !data_lines_oe_n)
    else $error("device output on during write");
  a_pulse_width: assert property ($fell(store_n) |-> (!store_n || good_q < RECOVERY_DELAY_CYC)[*6])
    else $error("store pulse too short");
  a_data_held: assert property (!store_n && ok_w |=> $stable(data_lines_out) && !data_lines_oe_n)
    else $error("write data moved");
  a_addr_stable: assert property (!select_low_n |=> select_low_n || $stable(address_lines))
    else $error("address moved in cycle");
  a_recover_gap: assert property ($rose(select_low_n) |=> select_low_n)
    else $error("no recovery gap");
  a_supply_quiet: assert property (!ok_w |=> select_low_n && !select_high && store_n && drive_n)
    else $error("bus active on bad supply");
  a_wait_recovery: assert property (!select_low_n |-> good_q >= RECOVERY_DELAY_CYC)
    else $error("select before recovery");
  a_alert_open: assert property (alert_oe_n)
    else $error("alert pin driven");
  c_write: cover property ($fell(store_n));
  c_read: cover property ($fell(drive_n));
  c_abort: cover property (!ok_w && !select_low_n);
endmodule // bcs_host_checker

bind bcs_host bcs_host_checker #(.RECOVERY_DELAY_CYC(RECOVERY_DELAY_CYC)) chk_u (.*);

// file: test/bcs_host_bench.sv
// Self-checking bench for the clock SRAM host controller
`define BCS_CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %0t got %h want %h", $time, g, e); end end
module bcs_host_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RECOVERY_DELAY = 8;
  logic        clk = 0;
  logic        rst = 1;
  logic [3:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic        reg_write = 0;
  logic        reg_read = 0;
  logic        supply_ok = 1;
  logic [31:0] reg_rdata, s, v;
  logic [12:0] address_lines, a;
  logic [7:0]  data_lines_out, data_lines_in, d;
  logic        data_lines_oe_n, select_low_n, select_high, store_n, drive_n;
  logic        alert_in, alert_out, alert_oe_n, alert_low;
  int          mismatches = 0;
  int          n_compared = 0;
  logic [7:0]  msk [8] = '{8'hFF, 8'hFF, 8'h7F, 8'h3F, 8'h07, 8'h3F, 8'h1F, 8'hFF};

  bcs_host #(.RECOVERY_DELAY_CYC(RECOVERY_DELAY)) dut_u (.*);
  bcs_dev_model m_u (.*, .dq(data_lines_in));
  // Pulled-up alert wire
  assign alert_in = !(alert_low || (!alert_oe_n && !alert_out));
  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////
  // One register bus cycle, strobe for one clock
  task automatic bus(input logic [3:0] ra, input logic [31:0] wd, input logic rd);
    @(posedge clk);
    reg_addr <= ra;
    reg_wdata <= wd;
    reg_write <= !rd;
    reg_read <= rd;
    @(posedge clk);
    reg_write <= 0;
    reg_read <= 0;
  endtask
  task automatic rdreg(input logic [3:0] ra, output logic [31:0] rv);
    bus(ra, 0, 1);
    #1 rv = reg_rdata;
  endtask
  // Device access through the command register
  task automatic dev(input logic [1:0] op, input logic [12:0] ad, input logic [7:0] dt);
    bus(0, 32'(ad), 0);
    bus(1, 32'(dt), 0);
    bus(2, 32'(op), 0);
    for (int i = 0; i < 40; i++) begin
      rdreg(3, s);
      if (s[1] === 1'b1 || s[2] === 1'b1) break;
    end
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (8000) @(posedge clk);
    mismatches++;
    results();
  end
  // Main sequence
  initial begin
    v = $urandom(32'h291A);
    repeat (4) @(posedge clk);
    rst <= 0;
    rdreg(3, s);
    `BCS_CHK(s[3], 1'b0)
    repeat (RECOVERY_DELAY) @(posedge clk);
    // Plain memory, edge addresses first
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FF7 : 13'($urandom_range(8183));
      d = 8'($urandom);
      dev(1, a, d);
      `BCS_CHK(s[2:0], 3'b010)
      `BCS_CHK(m_u.mem[a], d)
      dev(2, a, 0);
      rdreg(4, v);
      `BCS_CHK(v[7:0], d)
    end
    // Clock bytes, reserved bits written as zero
    for (int i = 0; i < 8; i++) begin
      a = 13'h1FF8 + 13'(i);
      d = (i == 0) ? (8'($urandom) | 8'h40) : 8'($urandom);
      dev(1, a, d);
      `BCS_CHK(m_u.mem[a], d & msk[i])
      dev(2, a, 0);
      rdreg(4, v);
      `BCS_CHK(v[7:0], d & msk[i])
    end
    // Supply loss in mid-write, then recovery
    dev(1, 13'h0123, 8'h5A);
    bus(0, 32'h0124, 0);
    bus(1, 32'hA5, 0);
    bus(2, 32'h1, 0);
    for (int i = 0; i < 20 && store_n; i++) @(negedge clk);
    @(posedge clk);
    supply_ok <= 0;
    repeat (3) @(posedge clk);
    `BCS_CHK(alert_in, 1'b0)
    rdreg(3, s);
    `BCS_CHK(s[4:0] & 5'h1D, 5'h14)
    `BCS_CHK(m_u.mem[13'h0123], 8'h5A)
    supply_ok <= 1;
    rdreg(3, s);
    `BCS_CHK(s[3], 1'b0)
    repeat (RECOVERY_DELAY + 4) @(posedge clk);
    dev(1, 13'h0124, 8'h3C);
    `BCS_CHK(m_u.mem[13'h0124], 8'h3C)
    results();
  end
endmodule // bcs_host_bench
